// File: tb_vid_powergood_supervisor.sv
// self-checking bench for the supervisor
`timescale 1ns/100ps
module tb_vid_powergood_supervisor;
  typedef struct {
    logic [5:0]  code;
    logic [20:0] uv;
  } vpgs_row_t;
  logic        clk;
  logic        rst;
  logic [5:0]  target;
  logic [5:0]  voltage_code;
  logic        undervoltage_lockout_ok, enable_cmp, window_ok, ss_near;
  logic        delay_reached, clamp_over, warn_cmp, shdn_cmp;
  logic        pg_o, pg_oe_n, tw_o, tw_oe_n, ts_o, ts_oe_n;
  logic        driver_disable_n, pwm_enable;
  logic        delay_discharge, ss_discharge;
  logic [5:0]  code_latched;
  logic [20:0] dac_uv;
  logic        hg, lg;
  int          bad_count, samples_checked, cycles;
  vpgs_row_t   rows [6];
  logic [5:0]  prev;
  // pull-ups on the open-drain pins
  wire pg_pin = pg_oe_n ? 1'b1 : pg_o;
  wire tw_pin = tw_oe_n ? 1'b1 : tw_o;
  wire ts_pin = ts_oe_n ? 1'b1 : ts_o;

  vpgs_top #(.CLAMP_BLANK_CYC(50), .PG_BLANK_CYC(100)) u_dut (
    .clk(clk), .rst(rst), .voltage_code(voltage_code),
    .undervoltage_lockout_ok(undervoltage_lockout_ok), .enable_cmp(enable_cmp), .window_ok(window_ok),
    .ss_near(ss_near), .delay_reached(delay_reached),
    .clamp_over(clamp_over), .warn_cmp(warn_cmp), .shdn_cmp(shdn_cmp),
    .power_good_i(pg_pin), .thermal_warn_flag_i(tw_pin),
    .thermal_shutdown_flag_i(ts_pin), .power_good_o(pg_o),
    .power_good_oe_n(pg_oe_n), .thermal_warn_flag_o(tw_o),
    .thermal_warn_flag_oe_n(tw_oe_n), .thermal_shutdown_flag_o(ts_o),
    .thermal_shutdown_flag_oe_n(ts_oe_n),
    .driver_disable_n(driver_disable_n), .pwm_enable(pwm_enable),
    .delay_discharge(delay_discharge), .ss_discharge(ss_discharge),
    .code_latched(code_latched), .dac_uv(dac_uv));

  vpgs_far_side u_far (
    .clk(clk), .rst(rst), .target(target),
    .driver_disable_n(driver_disable_n), .pwm_enable(pwm_enable),
    .voltage_code(voltage_code), .high_gate_drive(hg),
    .low_gate_drive(lg));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic check(logic [20:0] got, logic [20:0] exp, string msg);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // inputs move one small delay after the rising edge
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic goto_code(logic [5:0] c);
    int n;
    n = 0;
    target = c;
    while (voltage_code !== c && n < 800) begin
      step(1);
      n++;
    end
    step(50);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    samples_checked = 0;
    cycles = 0;
    rst = 1'b1;
    target = 6'h00;
    {undervoltage_lockout_ok, enable_cmp, window_ok, ss_near} = 4'h0;
    {delay_reached, clamp_over, warn_cmp, shdn_cmp} = 4'h0;
    rows = '{'{6'h01, 21'h174508}, '{6'h1F, 21'h0BD358},
             '{6'h20, 21'h0BA284}, '{6'h21, 21'h0B71B0},
             '{6'h3A, 21'h06ACFC}, '{6'h00, 21'h17A6B0}};
    step(2);
    check(pg_oe_n, 1'b0, "rst pg");
    check(driver_disable_n, 1'b0, "rst drv");
    check(pwm_enable, 1'b0, "rst pwm");
    check(delay_discharge, 1'b1, "rst dly");
    check(dac_uv, 21'h17A6B0, "rst dac");
    step(18);
    rst = 1'b0;
    step(2);
    $display("test reset done");
    prev = 6'h00;
    foreach (rows[i]) begin
      target = rows[i].code;
      step(20);
      check(code_latched, prev, "old code kept");
      goto_code(rows[i].code);
      check(code_latched, rows[i].code, "latched");
      check(dac_uv, rows[i].uv, "decode");
      prev = rows[i].code;
    end
    $display("test decode done");
    goto_code(6'h3F);
    undervoltage_lockout_ok = 1'b1;
    enable_cmp = 1'b1;
    step(10);
    check(driver_disable_n, 1'b0, "no cpu start");
    check(pg_oe_n, 1'b0, "no cpu pg");
    goto_code(6'h10);
    check(driver_disable_n, 1'b1, "start drv");
    check(pwm_enable, 1'b1, "start pwm");
    check(ss_discharge, 1'b0, "ss released");
    window_ok = 1'b1;
    step(8);
    check(pg_oe_n, 1'b0, "pg before ramp");
    ss_near = 1'b1;
    step(6);
    check(delay_discharge, 1'b0, "delay timing");
    check(pg_oe_n, 1'b0, "pg before delay");
    delay_reached = 1'b1;
    step(6);
    check(pg_oe_n, 1'b1, "pg released");
    $display("test startup done");
    step(150);
    target = 6'h11;
    step(20);
    window_ok = 1'b0;
    step(40);
    check(pg_oe_n, 1'b1, "pg blanked");
    step(100);
    check(pg_oe_n, 1'b0, "pg window");
    window_ok = 1'b1;
    step(150);
    $display("test pg blank done");
    target = 6'h12;
    step(20);
    clamp_over = 1'b1;
    step(20);
    check(pwm_enable, 1'b1, "clamp blanked");
    target = 6'h13;
    step(30);
    check(pwm_enable, 1'b1, "blank restart");
    step(40);
    check(pwm_enable, 1'b0, "clamp fires");
    clamp_over = 1'b0;
    $display("test clamp done");
    warn_cmp = 1'b1;
    step(6);
    check(tw_oe_n, 1'b1, "warn");
    enable_cmp = 1'b0;
    step(8);
    check(driver_disable_n, 1'b0, "off drv");
    check(pwm_enable, 1'b0, "off pwm");
    check(delay_discharge, 1'b1, "off dly");
    check(pg_oe_n, 1'b0, "off pg");
    check({hg, lg}, 2'b00, "gates grounded");
    check(tw_oe_n, 1'b1, "warn no enable");
    shdn_cmp = 1'b1;
    step(6);
    check(ts_oe_n, 1'b1, "shutdown");
    undervoltage_lockout_ok = 1'b0;
    step(8);
    check(tw_oe_n, 1'b0, "warn lockout");
    check(ts_oe_n, 1'b0, "shdn lockout");
    $display("test disable done");
    end_of_test();
  end
endmodule

// File: vpgs_far_side.sv
// processor code-pin stepper and external gate driver model
`timescale 1ns/100ps
module vpgs_far_side #(
  parameter int STEP_CYC = 10
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [5:0] target,
  input  wire logic       driver_disable_n,
  input  wire logic       pwm_enable,
  output logic [5:0]      voltage_code,
  output logic            high_gate_drive,
  output logic            low_gate_drive
);
  int   cnt;
  logic phase;
  // ----------------------------------------------------------------
  // code stepping
  // ----------------------------------------------------------------
  // one step per interval, never a jump, up or down
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      voltage_code <= 6'h00;
    end else if (voltage_code == target) begin
      cnt <= 0;
    end else if (cnt < STEP_CYC - 1) begin
      cnt <= cnt + 1;
    end else begin
      cnt <= 0;
      if (target > voltage_code) begin
        voltage_code <= #1 voltage_code + 6'h01;
      end else begin
        voltage_code <= #1 voltage_code - 6'h01;
      end
    end
  end
  // ----------------------------------------------------------------
  // gate driver
  // ----------------------------------------------------------------
  // stand-in switching phase, real drivers follow a pwm edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end
  assign high_gate_drive = driver_disable_n & pwm_enable & phase;
  assign low_gate_drive  = driver_disable_n
                           & ~(pwm_enable & phase);
endmodule

// File: vpgs_pin_if.sv
// raw and cleaned pin bundle between supervisor and input filter
`timescale 1ns/100ps
interface vpgs_pin_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport src  (output raw, input clean);
  modport filt (input raw, output clean);
endinterface

// File: vpgs_pkg.sv
// constants shared by the voltage-code and power-good supervisor
package vpgs_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int IGNORE_NS       = 400;
  localparam int IGNORE_CYC      = (IGNORE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int CLAMP_BLANK_US  = 100;
  localparam int CLAMP_BLANK_CYC = (CLAMP_BLANK_US * 1000 + CLK_PERIOD_NS
                                   - 1) / CLK_PERIOD_NS;
  localparam int PG_BLANK_US     = 200;
  localparam int PG_BLANK_CYC    = (PG_BLANK_US * 1000 + CLK_PERIOD_NS
                                   - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // voltage code layout and decode
  // ----------------------------------------------------------------
  localparam int          CODE_W      = 6;
  localparam int          CODE_RANGE  = 5;
  localparam int          DAC_W       = 21;
  localparam logic [20:0] HI_BASE_UV  = 21'h17A6B0;
  localparam logic [20:0] HI_STEP_UV  = 21'h0061A8;
  localparam logic [20:0] LO_BASE_UV  = 21'h0BA284;
  localparam logic [20:0] LO_STEP_UV  = 21'h0030D4;
  localparam logic [5:0]  CODE_RST    = 6'h00;
  localparam logic [5:0]  NO_CPU_CODE = 6'h3F;

  // ----------------------------------------------------------------
  // comparator bus bit positions
  // ----------------------------------------------------------------
  localparam int CMP_W      = 8;
  localparam int CMP_UNDERVOLTAGE_LOCKOUT   = 0;
  localparam int CMP_EN     = 1;
  localparam int CMP_WINDOW = 2;
  localparam int CMP_SSNEAR = 3;
  localparam int CMP_DELAY  = 4;
  localparam int CMP_CLAMP  = 5;
  localparam int CMP_WARN   = 6;
  localparam int CMP_SHDN   = 7;

  typedef enum logic [3:0] {
    VPGS_OFF   = 4'h1,
    VPGS_RAMP  = 4'h2,
    VPGS_DELAY = 4'h4,
    VPGS_RUN   = 4'h8
  } vpgs_state_t;

endpackage

// File: vpgs_sync.sv
// three-stage input filter, change taken when stages two and three agree
`timescale 1ns/100ps
module vpgs_sync #(
  parameter int W = 1
) (
  input  wire logic clk,
  input  wire logic rst,
  vpgs_pin_if.filt  pins
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] clean;

  initial begin
    if (W < 1) $error("vpgs_sync: width must be at least one");
  end

  // ----------------------------------------------------------------
  // stage one feeds only stage two
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pins.raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // per bit: take the value only once two stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clean <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          clean[i] <= stage3[i];
        end
      end
    end
  end

  assign pins.clean = clean;
endmodule

// File: vpgs_top.sv
// voltage-code, power-good, clamp and thermal flag supervisor
`timescale 1ns/100ps

module vpgs_top #(
  parameter int CLAMP_BLANK_CYC = vpgs_pkg::CLAMP_BLANK_CYC,
  parameter int PG_BLANK_CYC    = vpgs_pkg::PG_BLANK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  voltage_code,
  input  wire logic        undervoltage_lockout_ok,
  input  wire logic        enable_cmp,
  input  wire logic        window_ok,
  input  wire logic        ss_near,
  input  wire logic        delay_reached,
  input  wire logic        clamp_over,
  input  wire logic        warn_cmp,
  input  wire logic        shdn_cmp,
  input  wire logic        power_good_i,
  input  wire logic        thermal_warn_flag_i,
  input  wire logic        thermal_shutdown_flag_i,
  output logic             power_good_o,
  output logic             power_good_oe_n,
  output logic             thermal_warn_flag_o,
  output logic             thermal_warn_flag_oe_n,
  output logic             thermal_shutdown_flag_o,
  output logic             thermal_shutdown_flag_oe_n,
  output logic             driver_disable_n,
  output logic             pwm_enable,
  output logic             delay_discharge,
  output logic             ss_discharge,
  output logic [5:0]       code_latched,
  output logic [20:0]      dac_uv
);
  localparam int CW = vpgs_pkg::CODE_W;

  vpgs_pin_if #(.W(CW))              code_pins ();
  vpgs_pin_if #(.W(vpgs_pkg::CMP_W)) cmp_pins ();

  vpgs_pkg::vpgs_state_t state;
  vpgs_pkg::vpgs_state_t next_state;
  logic [CW-1:0]  code_s;
  logic [CW-1:0]  code_prev;
  logic [7:0]     cmp_s;
  logic           code_chg;
  logic [7:0]     ign_cnt;
  logic [15:0]    clamp_cnt;
  logic [15:0]    pg_cnt;
  logic           ign_active;
  logic           clamp_blank;
  logic           pg_blank;
  logic           code_valid;
  logic           run_ok;
  logic           clamp_fire;
  logic           power_good;
  logic           warn_flag;
  logic           shdn_flag;

  initial begin
    if (CLAMP_BLANK_CYC < 1 || CLAMP_BLANK_CYC > 65535)
      $error("vpgs_top: clamp blanking count out of range");
    if (PG_BLANK_CYC < 1 || PG_BLANK_CYC > 65535)
      $error("vpgs_top: power good blanking count out of range");
  end

  // ----------------------------------------------------------------
  // pin filters
  // ----------------------------------------------------------------
  assign code_pins.raw = voltage_code;
  assign cmp_pins.raw  = {shdn_cmp, warn_cmp, clamp_over, delay_reached,
                          ss_near, window_ok, enable_cmp, undervoltage_lockout_ok};
  assign code_s        = code_pins.clean;
  assign cmp_s         = cmp_pins.clean;

  vpgs_sync #(.W(CW)) u_code_sync (
    .clk  (clk),
    .rst  (rst),
    .pins (code_pins)
  );

  vpgs_sync #(.W(vpgs_pkg::CMP_W)) u_cmp_sync (
    .clk  (clk),
    .rst  (rst),
    .pins (cmp_pins)
  );

  // ----------------------------------------------------------------
  // code change detect and ignore window
  // ----------------------------------------------------------------
  assign code_chg = (code_s != code_prev);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_prev <= vpgs_pkg::CODE_RST;
    end else begin
      code_prev <= code_s;
    end
  end

  // skew between the six inputs would otherwise decode a false code
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ign_cnt <= 8'h00;
    end else if (code_chg) begin
      ign_cnt <= 8'(vpgs_pkg::IGNORE_CYC);
    end else if (ign_cnt != 8'h00) begin
      ign_cnt <= ign_cnt - 8'h01;
    end
  end
  assign ign_active = (ign_cnt != 8'h00);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_latched <= vpgs_pkg::CODE_RST;
    end else if (ign_cnt == 8'h01 && !code_chg) begin
      code_latched <= code_s;
    end
  end

  // decode of the latched code, in microvolts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_uv <= vpgs_pkg::HI_BASE_UV;
    end else if (code_latched[vpgs_pkg::CODE_RANGE]) begin
      dac_uv <= vpgs_pkg::LO_BASE_UV - 21'(code_latched[4:0]
                * vpgs_pkg::LO_STEP_UV);
    end else begin
      dac_uv <= vpgs_pkg::HI_BASE_UV - 21'(code_latched[4:0]
                * vpgs_pkg::HI_STEP_UV);
    end
  end

  // ----------------------------------------------------------------
  // blanking timers
  // ----------------------------------------------------------------
  // every step of a stepped transition reloads, so blanking spans it all
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clamp_cnt <= 16'h0000;
    end else if (code_chg) begin
      clamp_cnt <= 16'(CLAMP_BLANK_CYC);
    end else if (clamp_cnt != 16'h0000) begin
      clamp_cnt <= clamp_cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pg_cnt <= 16'h0000;
    end else if (code_chg) begin
      pg_cnt <= 16'(PG_BLANK_CYC);
    end else if (pg_cnt != 16'h0000) begin
      pg_cnt <= pg_cnt - 16'h0001;
    end
  end
  assign clamp_blank = (clamp_cnt != 16'h0000);
  assign pg_blank    = (pg_cnt != 16'h0000);

  // ----------------------------------------------------------------
  // start-up sequencer
  // ----------------------------------------------------------------
  assign code_valid = (code_latched != vpgs_pkg::NO_CPU_CODE);
  assign run_ok     = cmp_s[vpgs_pkg::CMP_UNDERVOLTAGE_LOCKOUT] && cmp_s[vpgs_pkg::CMP_EN];

  always_comb begin
    next_state = state;
    case (state)
      vpgs_pkg::VPGS_OFF: begin
        if (run_ok && code_valid && !ign_active)
          next_state = vpgs_pkg::VPGS_RAMP;
      end
      vpgs_pkg::VPGS_RAMP: begin
        if (cmp_s[vpgs_pkg::CMP_SSNEAR])
          next_state = vpgs_pkg::VPGS_DELAY;
      end
      vpgs_pkg::VPGS_DELAY: begin
        if (cmp_s[vpgs_pkg::CMP_DELAY])
          next_state = vpgs_pkg::VPGS_RUN;
      end
      vpgs_pkg::VPGS_RUN: begin
        next_state = vpgs_pkg::VPGS_RUN;
      end
      default: begin
        next_state = vpgs_pkg::VPGS_OFF;
      end
    endcase
    if (!run_ok)
      next_state = vpgs_pkg::VPGS_OFF;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= vpgs_pkg::VPGS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // switching, clamp and timing-pin control
  // ----------------------------------------------------------------
  // low pwm turns the low-side switches on and pulls the output down
  assign clamp_fire = cmp_s[vpgs_pkg::CMP_CLAMP] && !clamp_blank;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_enable       <= 1'b0;
      driver_disable_n <= 1'b0;
      delay_discharge  <= 1'b1;
      ss_discharge     <= 1'b1;
    end else begin
      pwm_enable       <= (next_state != vpgs_pkg::VPGS_OFF)
                          && !clamp_fire;
      driver_disable_n <= (next_state != vpgs_pkg::VPGS_OFF);
      delay_discharge  <= (next_state == vpgs_pkg::VPGS_OFF)
                          || (next_state == vpgs_pkg::VPGS_RAMP);
      ss_discharge     <= (next_state == vpgs_pkg::VPGS_OFF);
    end
  end

  // ----------------------------------------------------------------
  // power good
  // ----------------------------------------------------------------
  // while blanked a good output holds; window faults only show once unblanked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_good <= 1'b0;
    end else begin
      power_good <= (next_state == vpgs_pkg::VPGS_RUN) && code_valid
                    && (cmp_s[vpgs_pkg::CMP_WINDOW]
                        || (pg_blank && power_good));
    end
  end

  // ----------------------------------------------------------------
  // thermal flags
  // ----------------------------------------------------------------
  // hysteresis lives in the comparators; flags track them while undervoltage lockout is ok
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warn_flag <= 1'b0;
      shdn_flag <= 1'b0;
    end else begin
      warn_flag <= cmp_s[vpgs_pkg::CMP_UNDERVOLTAGE_LOCKOUT]
                   && cmp_s[vpgs_pkg::CMP_WARN];
      shdn_flag <= cmp_s[vpgs_pkg::CMP_UNDERVOLTAGE_LOCKOUT]
                   && cmp_s[vpgs_pkg::CMP_SHDN];
    end
  end

  // open drain: drive low when the flag is low, release otherwise
  assign power_good_o               = 1'b0;
  assign power_good_oe_n            = power_good;
  assign thermal_warn_flag_o        = 1'b0;
  assign thermal_warn_flag_oe_n     = warn_flag;
  assign thermal_shutdown_flag_o    = 1'b0;
  assign thermal_shutdown_flag_oe_n = shdn_flag;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ignore_hold_a: assert property (
    code_chg |=> ign_active [*8])
    else $error("ignore window not held after code change");
  code_keep_a: assert property (
    (ign_cnt > 8'h01) |=> $stable(code_latched))
    else $error("latched code moved inside ignore window");
  blank_start_a: assert property (
    code_chg |=> clamp_blank && pg_blank)
    else $error("blanking not started by code change");
  blank_restart_a: assert property (
    code_chg |=> (clamp_cnt == 16'(CLAMP_BLANK_CYC))
                 && (pg_cnt == 16'(PG_BLANK_CYC)))
    else $error("blanking timer not restarted");
  pg_off_a: assert property (
    !cmp_s[vpgs_pkg::CMP_EN] |=> !power_good)
    else $error("power good high with enable low");
  pg_ramp_a: assert property (
    (state != vpgs_pkg::VPGS_RUN) |-> !power_good)
    else $error("power good before delay done");
  pg_blank_a: assert property (
    (power_good && pg_blank && run_ok && code_valid
     && state == vpgs_pkg::VPGS_RUN) |=> power_good)
    else $error("power good dropped while blanked");
  clamp_low_a: assert property (
    (clamp_fire && state != vpgs_pkg::VPGS_OFF) |=> !pwm_enable)
    else $error("clamp did not force pwm low");
  start_cond_a: assert property (
    $rose(driver_disable_n) |-> $past(run_ok) && $past(code_valid))
    else $error("start without all conditions");
  disable_a: assert property (
    !run_ok |=> !pwm_enable && !driver_disable_n && delay_discharge
                && !power_good)
    else $error("disable did not shut outputs");
  thermal_off_a: assert property (
    !cmp_s[vpgs_pkg::CMP_UNDERVOLTAGE_LOCKOUT] |=> !warn_flag && !shdn_flag)
    else $error("thermal flag high under lockout");
  thermal_track_a: assert property (
    cmp_s[vpgs_pkg::CMP_UNDERVOLTAGE_LOCKOUT] && cmp_s[vpgs_pkg::CMP_WARN]
    && !cmp_s[vpgs_pkg::CMP_EN] |=> warn_flag)
    else $error("warn flag not tracking comparator");
  decode_a: assert property (
    $stable(code_latched) && code_latched == 6'h3A |=>
      dac_uv == 21'h06ACFC)
    else $error("code decode wrong");

  otf_cov: cover property (state == vpgs_pkg::VPGS_RUN && code_chg);
  pg_up_cov: cover property ($rose(power_good));
  clamp_cov: cover property (clamp_fire && state == vpgs_pkg::VPGS_RUN);
  warn_cov: cover property ($rose(warn_flag));
endmodule
